// file: include/cprl_pkg.sv
// shared constants and types for the coprocessor repeat-loop and issue-pipeline block
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// RULE1: end address is low 7 bits of pc+1+size
// RULE2: end address field sits in bits 22:16
// RULE3: zero count runs once, active flag clear
// RULE4: counter loads on repeat, decrements at end
// RULE5: count zero clears active, block runs count+1
// RULE6: decode stage two classifies host, float, coprocessor
// RULE7: host stall or wait state stalls coprocessor
// RULE8: most coprocessor ops finish in one cycle
// RULE9: pipelined op issues every cycle, result later
// RULE10: rate one third branch metric is pipelined
// RULE11: complex multiply and mac are pipelined
// RULE12: all other ops need no delay slot
// RULE13: complex multiply writes back one cycle later
// RULE14: next instruction avoids pipelined destinations
// RULE15: parallel opcode: pipelined part two, move one
// RULE16: delay slot never writes pipelined destination
// RULE17: any instruction class may fill delay slot; a single-cycle coproc op there is not written back
// RULE18: active flag bit 30 set on repeat
// RULE19: interrupt shadows active flag in bit 31
// RULE20: block size 7 bits in 29:23 from opcode
// RULE21: active and pc at end redirects fetch; the code also requires a nonzero loop_repeat_count
package cprl_pkg;
    // register map, byte addresses
    localparam logic [31:0] REPEAT_BLOCK_STATE_ADDR = 32'h0000_0000;
    localparam logic [31:0] ISSUE_STATUS_ADDR       = 32'h0000_0004;
    localparam logic [31:0] CONTROL_ADDR            = 32'h0000_0008;
    localparam logic [31:0] REPEAT_BLOCK_STATE_RST  = 32'h0000_0000;
    localparam logic [31:0] CONTROL_RST             = 32'h0000_0000;
    // repeat_block_state field positions
    localparam int SHADOW_BIT   = 31;
    localparam int ACTIVE_BIT   = 30;
    localparam int SIZE_LSB     = 23;
    localparam int END_LSB      = 16;
    localparam int COUNT_LSB    = 0;
    localparam int ADDR_W       = 7;
    localparam int COUNT_W      = 16;
    localparam int PC_W         = 22;
    // control bits
    localparam int CTRL_ENABLE_BIT = 0;
    // issue status bits
    localparam int STAT_PEND_BIT   = 0;
    localparam int STAT_CLASS_LSB  = 1;
    localparam int STAT_STALL_BIT  = 3;
    // pipelined operation latency in cycles
    localparam int PIPE_LATENCY    = 2;

    typedef enum logic [1:0] {
        CPRL_CLASS_HOST,
        CPRL_CLASS_FLOAT,
        CPRL_CLASS_COPROC,
        CPRL_CLASS_NONE
    } cprl_class_type;

    typedef enum logic [2:0] {
        CPRL_OP_SINGLE,
        CPRL_OP_BM_RATE3,
        CPRL_OP_CMPY,
        CPRL_OP_CMAC,
        CPRL_OP_MOVE
    } cprl_op_type;
endpackage

// file: src/cprl_core.sv
// coprocessor repeat-block sequencer, decode classification and write-back timing
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module cprl_core #(
    parameter int RESULT_W = 32,
    parameter int REG_W    = 4
) (
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    // ahb-lite slave
    input  wire logic                        hsel,
    input  wire logic [31:0]                 haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    // host pipeline
    input  wire logic                        host_stall,
    input  wire logic                        mem_wait,
    input  wire logic                        instr_valid,
    input  wire logic                        instr_is_float,
    input  wire logic                        instr_is_coproc,
    input  wire cprl_pkg::cprl_op_type       instr_op,
    input  wire logic                        instr_has_move,
    input  wire logic [REG_W-1:0]            instr_dest,
    input  wire logic [RESULT_W-1:0]         instr_result,
    input  wire logic [cprl_pkg::PC_W-1:0]   pc,
    input  wire logic                        repeat_exec,
    input  wire logic [cprl_pkg::ADDR_W-1:0] repeat_size,
    input  wire logic [cprl_pkg::COUNT_W-1:0] repeat_count,
    input  wire logic                        irq_entry,
    input  wire logic                        irq_return,
    // outputs
    output cprl_pkg::cprl_class_type         decode_class,
    output logic                             coproc_advance,
    output logic                             wb_valid,
    output logic      [REG_W-1:0]            wb_dest,
    output logic      [RESULT_W-1:0]         wb_data,
    output logic                             move_wb_valid,
    output logic                             loop_redirect,
    output logic      [cprl_pkg::PC_W-1:0]   loop_target,
    output logic                             loop_active_flag
);
    import cprl_pkg::*;

    //------------------------------------------------------------
    // repeat-block state
    //------------------------------------------------------------
    logic                 loop_shadow;
    logic [ADDR_W-1:0]    loop_block_size;
    logic [ADDR_W-1:0]    loop_end_address;
    logic [COUNT_W-1:0]   loop_repeat_count;
    logic [PC_W-1:0]      loop_start;
    logic [31:0]          repeat_block_state;
    logic [31:0]          control;
    logic                 advance;
    logic                 at_end;
    logic                 enabled;

    assign enabled = control[CTRL_ENABLE_BIT];
    assign advance = !host_stall && !mem_wait; // RULE7
    assign coproc_advance = advance;
    assign at_end = advance && instr_valid && loop_active_flag
                    && (pc[ADDR_W-1:0] == loop_end_address);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_block_size  <= '0;
            loop_end_address <= '0;
            loop_start       <= '0;
        end else if (advance && repeat_exec && enabled) begin
            loop_block_size  <= repeat_size; // RULE20
            // ends one word before the next instruction past the block
            loop_end_address <= ADDR_W'(pc + PC_W'(1) + PC_W'(repeat_size)); // RULE1
            loop_start       <= PC_W'(pc + PC_W'(1));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_repeat_count <= '0;
        end else if (advance && repeat_exec && enabled) begin
            loop_repeat_count <= repeat_count; // RULE4
        end else if (at_end && loop_repeat_count != '0) begin
            loop_repeat_count <= loop_repeat_count - COUNT_W'(1); // RULE4
        end
    end

    // interrupt bookkeeping beats loop events on the active flag in the same cycle; the count still loads or decrements
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            loop_active_flag <= 1'b0;
            loop_shadow      <= 1'b0;
        end else if (irq_entry) begin
            loop_shadow      <= loop_active_flag; // RULE19
            loop_active_flag <= 1'b0;
        end else if (irq_return) begin
            loop_active_flag <= loop_shadow; // RULE19
            loop_shadow      <= 1'b0;
        end else if (advance && repeat_exec && enabled) begin
            loop_active_flag <= (repeat_count != '0); // RULE18 RULE3
        end else if (at_end && loop_repeat_count == COUNT_W'(1)) begin
            // last decrement: clear now, final pass runs unredirected
            loop_active_flag <= 1'b0; // RULE5
        end
    end

    // redirect while more passes remain; the pass after reaching zero falls through
    assign loop_redirect = at_end && (loop_repeat_count != '0); // RULE21 RULE5
    assign loop_target   = loop_start;

    assign repeat_block_state = {loop_shadow, loop_active_flag, loop_block_size,
                                 loop_end_address, loop_repeat_count}; // RULE2

    //------------------------------------------------------------
    // decode stage two classification
    //------------------------------------------------------------
    always_comb begin
        if (!instr_valid) begin
            decode_class = CPRL_CLASS_NONE;
        end else if (instr_is_coproc) begin
            decode_class = CPRL_CLASS_COPROC; // RULE6
        end else if (instr_is_float) begin
            decode_class = CPRL_CLASS_FLOAT;
        end else begin
            decode_class = CPRL_CLASS_HOST;
        end
    end

    //------------------------------------------------------------
    // execute and write-back timing
    //------------------------------------------------------------
    logic is_coproc;
    logic is_pipelined;
    logic pend_valid;
    logic [REG_W-1:0] pend_dest;
    logic [RESULT_W-1:0] pend_data;

    assign is_coproc = advance && decode_class == CPRL_CLASS_COPROC;
    always_comb begin
        case (instr_op)
            CPRL_OP_BM_RATE3: is_pipelined = 1'b1; // RULE10
            CPRL_OP_CMPY:     is_pipelined = 1'b1; // RULE11 RULE13
            CPRL_OP_CMAC:     is_pipelined = 1'b1; // RULE11
            default:          is_pipelined = 1'b0; // RULE12
        endcase
    end

    // second stage of a pipelined op; a new issue may enter every cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_valid <= 1'b0;
            pend_dest  <= '0;
            pend_data  <= '0;
        end else if (advance) begin
            pend_valid <= is_coproc && is_pipelined; // RULE9
            pend_dest  <= instr_dest;
            pend_data  <= instr_result;
        end
    end

    // in the slot cycle wb takes only the pending result; a single-cycle coproc result issued there is dropped, its move part still sets move_wb_valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wb_valid      <= 1'b0;
            wb_dest       <= '0;
            wb_data       <= '0;
            move_wb_valid <= 1'b0;
        end else if (!advance) begin
            wb_valid      <= 1'b0; // RULE7
            move_wb_valid <= 1'b0;
        end else if (pend_valid) begin
            wb_valid      <= 1'b1; // RULE9 RULE13 RULE16
            wb_dest       <= pend_dest;
            wb_data       <= pend_data;
            move_wb_valid <= is_coproc && instr_has_move; // RULE15
        end else begin
            wb_valid      <= is_coproc && !is_pipelined; // RULE8
            wb_dest       <= instr_dest;
            wb_data       <= instr_result;
            move_wb_valid <= is_coproc && instr_has_move; // RULE15
        end
    end

    //------------------------------------------------------------
    // ahb-lite slave, zero wait states
    //------------------------------------------------------------
    logic        dp_write;
    logic        dp_read;
    logic [31:0] dp_addr;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= '0;
        end else if (hready) begin
            dp_write <= hsel && htrans[1] && hwrite;
            dp_read  <= hsel && htrans[1] && !hwrite;
            dp_addr  <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            control <= CONTROL_RST;
        end else if (dp_write && dp_addr == CONTROL_ADDR) begin
            control <= {31'h0000_0000, hwdata[CTRL_ENABLE_BIT]};
        end
    end

    always_comb begin
        hrdata = 32'h0000_0000;
        if (dp_read) begin
            case (dp_addr)
                REPEAT_BLOCK_STATE_ADDR: hrdata = repeat_block_state;
                ISSUE_STATUS_ADDR:       hrdata = {28'h000_0000, !advance, decode_class, pend_valid};
                CONTROL_ADDR:            hrdata = control;
                default:                 hrdata = 32'h0000_0000;
            endcase
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    sequence s_pipe_issue;
        advance && is_coproc && is_pipelined;
    endsequence
    sequence s_slot_advance;
        s_pipe_issue ##1 advance;
    endsequence

    // a stall in the slot cycle defers the write-back, so only the advancing slot is checked
    property p_pipe_wb;
        @(posedge hclk) disable iff (!hresetn) s_slot_advance |=> wb_valid;
    endproperty
    a_pipe_wb: assert property (p_pipe_wb) else $error("pipelined result not written back"); // RULE9

    // move half of a parallel opcode lands one cycle after issue, pipelined or not
    property p_move_wb;
        @(posedge hclk) disable iff (!hresetn) (advance && is_coproc && instr_has_move) |=> move_wb_valid;
    endproperty
    a_move_wb: assert property (p_move_wb) else $error("move part not written back"); // RULE15

    property p_single_wb;
        @(posedge hclk) disable iff (!hresetn)
            (advance && is_coproc && !is_pipelined && !pend_valid) |=> wb_valid;
    endproperty
    a_single_wb: assert property (p_single_wb) else $error("single-cycle result missing"); // RULE8

    property p_stall_quiet;
        @(posedge hclk) disable iff (!hresetn) (host_stall || mem_wait) |=> !wb_valid && !move_wb_valid;
    endproperty
    a_stall_quiet: assert property (p_stall_quiet) else $error("write-back during stall"); // RULE7

    property p_end_calc;
        @(posedge hclk) disable iff (!hresetn) (advance && repeat_exec && enabled && !irq_entry && !irq_return)
            |=> loop_end_address == ADDR_W'($past(pc) + PC_W'(1) + PC_W'($past(repeat_size)));
    endproperty
    a_end_calc: assert property (p_end_calc) else $error("end address wrong"); // RULE1

    property p_zero_count;
        @(posedge hclk) disable iff (!hresetn) (advance && repeat_exec && enabled && repeat_count == '0
            && !irq_entry && !irq_return) |=> !loop_active_flag;
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("active flag set for zero count"); // RULE3

    property p_decrement;
        @(posedge hclk) disable iff (!hresetn) (at_end && !repeat_exec && loop_repeat_count != '0)
            |=> loop_repeat_count == $past(loop_repeat_count) - COUNT_W'(1);
    endproperty
    a_decrement: assert property (p_decrement) else $error("count not decremented"); // RULE4

    property p_last_clear;
        @(posedge hclk) disable iff (!hresetn) (at_end && loop_repeat_count == COUNT_W'(1)
            && !repeat_exec && !irq_entry && !irq_return) |=> !loop_active_flag;
    endproperty
    a_last_clear: assert property (p_last_clear) else $error("active not cleared at zero"); // RULE5

    property p_set_active;
        @(posedge hclk) disable iff (!hresetn) (advance && repeat_exec && enabled && repeat_count != '0
            && !irq_entry && !irq_return) |=> loop_active_flag && repeat_block_state[ACTIVE_BIT];
    endproperty
    a_set_active: assert property (p_set_active) else $error("active flag not set"); // RULE18

    property p_irq_shadow;
        @(posedge hclk) disable iff (!hresetn) irq_entry
            |=> !loop_active_flag && loop_shadow == $past(loop_active_flag);
    endproperty
    a_irq_shadow: assert property (p_irq_shadow) else $error("shadow copy wrong"); // RULE19

    property p_redirect;
        @(posedge hclk) disable iff (!hresetn) loop_redirect |-> loop_active_flag
            && pc[ADDR_W-1:0] == repeat_block_state[END_LSB +: ADDR_W];
    endproperty
    a_redirect: assert property (p_redirect) else $error("redirect away from end"); // RULE21 RULE2
endmodule

// file: tb/cprl_host_model.sv
// host pipeline model feeding decode stage two, stalls and repeat events
`timescale 1ns/10ps
module cprl_host_model (
    input  wire logic                         hclk,
    input  wire logic                         loop_redirect,
    output logic                              host_stall,
    output logic                              mem_wait,
    output logic                              instr_valid,
    output logic                              instr_is_float,
    output logic                              instr_is_coproc,
    output cprl_pkg::cprl_op_type             instr_op,
    output logic                              instr_has_move,
    output logic [3:0]                        instr_dest,
    output logic [31:0]                       instr_result,
    output logic [cprl_pkg::PC_W-1:0]         pc,
    output logic                              repeat_exec,
    output logic [cprl_pkg::ADDR_W-1:0]       repeat_size,
    output logic [cprl_pkg::COUNT_W-1:0]      repeat_count,
    output logic                              irq_entry,
    output logic                              irq_return
);
    import cprl_pkg::*;
    initial begin
        {host_stall, mem_wait, instr_valid, instr_is_float, instr_is_coproc, instr_has_move} = '0;
        {repeat_exec, irq_entry, irq_return, instr_dest, instr_result, pc, repeat_size, repeat_count} = '0;
        instr_op = CPRL_OP_SINGLE;
    end
    //------------------------------------------------------------
    // instruction stream
    //------------------------------------------------------------
    task automatic show(input logic v, input logic f, input logic c);
        instr_valid     <= v;
        instr_is_float  <= f;
        instr_is_coproc <= c;
    endtask
    // callers never put a single-cycle coproc op right after a pipelined one
    task automatic issue(input cprl_op_type op, input logic f, input logic c, input logic mv,
                         input logic [3:0] d, input logic [31:0] r);
        show(1'b1, f, c);
        instr_op       <= op;
        instr_has_move <= mv;
        instr_dest     <= d;
        instr_result   <= r;
        do @(posedge hclk); while (host_stall || mem_wait);
    endtask
    task automatic hold(input logic hs, input logic mw);
        host_stall <= hs;
        mem_wait   <= mw;
    endtask
    //------------------------------------------------------------
    // repeat block and interrupts
    //------------------------------------------------------------
    task automatic rpt(input logic [PC_W-1:0] p, input logic [ADDR_W-1:0] s, input logic [COUNT_W-1:0] c);
        pc           <= p;
        repeat_size  <= s;
        repeat_count <= c;
        repeat_exec  <= 1'b1;
        @(posedge hclk);
        repeat_exec  <= 1'b0;
    endtask
    // one cycle at the block end, then fetch resumes at t
    task automatic step_pc(input logic [PC_W-1:0] e, input logic [PC_W-1:0] t, output logic r);
        pc          <= e;
        instr_valid <= 1'b1;
        @(negedge hclk);
        r = loop_redirect;
        @(posedge hclk);
        pc          <= t;
        instr_valid <= 1'b0;
        @(posedge hclk);
    endtask
    task automatic irq(input logic ent);
        irq_entry  <= ent;
        irq_return <= !ent;
        @(posedge hclk);
        irq_entry  <= 1'b0;
        irq_return <= 1'b0;
    endtask
endmodule

// file: tb/test_cprl_core.sv
// self-checking bench for the coprocessor repeat-loop block
`timescale 1ns/10ps
module test_cprl_core;
    import cprl_pkg::*;
    localparam logic [PC_W-1:0]   RPT_PC   = 22'h00017A;
    localparam logic [PC_W-1:0]   END_PC   = 22'h000184;
    localparam logic [ADDR_W-1:0] RPT_SIZE = 7'h09;
    logic               hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0]        haddr, hwdata, hrdata, instr_result, wb_data, q;
    logic [1:0]         htrans;
    logic [2:0]         hsize;
    logic               host_stall, mem_wait, instr_valid, instr_is_float, instr_is_coproc, instr_has_move;
    logic               repeat_exec, irq_entry, irq_return, coproc_advance, wb_valid, move_wb_valid;
    logic               loop_redirect, loop_active_flag, r;
    logic [3:0]         instr_dest, wb_dest;
    logic [PC_W-1:0]    pc, loop_target;
    logic [ADDR_W-1:0]  repeat_size, end_a;
    logic [COUNT_W-1:0] repeat_count;
    cprl_op_type        instr_op, op;
    cprl_class_type     decode_class;
    int                 bad_count, compares, i, p;
    logic [15:0]        cnt [3]    = '{16'd0, 16'd1, 16'd2};
    logic [2:0]         dec_in [5] = '{3'b000, 3'b100, 3'b110, 3'b101, 3'b111};
    cprl_class_type     dec_ex [5] = '{CPRL_CLASS_NONE, CPRL_CLASS_HOST, CPRL_CLASS_FLOAT, CPRL_CLASS_COPROC,
                                       CPRL_CLASS_COPROC};
    assign hready = hreadyout;
    assign end_a  = 7'(RPT_PC + 1 + RPT_SIZE);
    cprl_core cprl_core_i (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
        .host_stall, .mem_wait, .instr_valid, .instr_is_float, .instr_is_coproc, .instr_op, .instr_has_move,
        .instr_dest, .instr_result, .pc, .repeat_exec, .repeat_size, .repeat_count, .irq_entry, .irq_return,
        .decode_class, .coproc_advance, .wb_valid, .wb_dest, .wb_data, .move_wb_valid, .loop_redirect,
        .loop_target, .loop_active_flag
    );
    cprl_host_model cprl_host_model_i (
        .hclk, .loop_redirect, .host_stall, .mem_wait, .instr_valid, .instr_is_float, .instr_is_coproc,
        .instr_op, .instr_has_move, .instr_dest, .instr_result, .pc, .repeat_exec, .repeat_size,
        .repeat_count, .irq_entry, .irq_return
    );
    //------------------------------------------------------------
    // tasks
    //------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] o);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        o = hrdata;
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string n);
        ahb(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask
    // first cycle after the call in which a result is written back
    task automatic wait_wb(input int n, input logic [3:0] d, input logic [31:0] v);
        for (p = 1; p < 6; p++) begin
            @(negedge hclk);
            if (wb_valid === 1'b1) break;
        end
        chk("wb_latency", n, p);
        chk("wb_dest", d, wb_dest);
        chk("wb_data", v, wb_data);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    //------------------------------------------------------------
    // clock, reset, watchdog and tests
    //------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    initial begin
        repeat (4000) @(posedge hclk);
        bad_count++;
        finish_test();
    end
    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, hresetn} = '0;
        hsize = 3'b010;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(REPEAT_BLOCK_STATE_ADDR, REPEAT_BLOCK_STATE_RST, "state_reset");
        rdchk(CONTROL_ADDR, CONTROL_RST, "control_reset");
        cprl_host_model_i.rpt(RPT_PC, RPT_SIZE, 16'd3);
        rdchk(REPEAT_BLOCK_STATE_ADDR, 32'h0, "repeat_disabled");
        ahb(1'b1, REPEAT_BLOCK_STATE_ADDR, 32'hFFFF_FFFF, q);
        rdchk(REPEAT_BLOCK_STATE_ADDR, 32'h0, "state_read_only");
        ahb(1'b1, 32'h0000_000C, 32'hFFFF_FFFF, q);
        rdchk(32'h0000_000C, 32'h0, "unmapped");
        ahb(1'b1, CONTROL_ADDR, 32'h1, q);
        rdchk(CONTROL_ADDR, 32'h1, "control_enable");
        chk("hresp", 0, hresp);
        chk("hreadyout", 1, hreadyout);
        $display("test registers done");
        for (i = 0; i < 3; i++) begin
            cprl_host_model_i.rpt(RPT_PC, RPT_SIZE, cnt[i]);
            @(negedge hclk);
            chk("active", cnt[i] != 0, loop_active_flag);
            chk("target", RPT_PC + 1, loop_target);
            rdchk(REPEAT_BLOCK_STATE_ADDR, {1'b0, cnt[i] != 0, RPT_SIZE, end_a, cnt[i]}, "load");
            for (int n = 0; n <= cnt[i]; n++) begin
                cprl_host_model_i.step_pc(END_PC, RPT_PC + 1, r);
                chk("redirect", n < cnt[i], r);
            end
            rdchk(REPEAT_BLOCK_STATE_ADDR, {2'b00, RPT_SIZE, end_a, 16'h0}, "loop_end");
        end
        cprl_host_model_i.rpt(RPT_PC, RPT_SIZE, 16'd4);
        cprl_host_model_i.irq(1'b1);
        rdchk(REPEAT_BLOCK_STATE_ADDR, {2'b10, RPT_SIZE, end_a, 16'd4}, "irq_entry");
        cprl_host_model_i.irq(1'b0);
        rdchk(REPEAT_BLOCK_STATE_ADDR, {2'b01, RPT_SIZE, end_a, 16'd4}, "irq_return");
        $display("test repeat loop done");
        cprl_host_model_i.hold(1'b1, 1'b0);
        for (i = 0; i < 5; i++) begin
            cprl_host_model_i.show(dec_in[i][2], dec_in[i][1], dec_in[i][0]);
            @(negedge hclk);
            chk("class", dec_ex[i], decode_class);
            chk("advance_stalled", 0, coproc_advance);
        end
        rdchk(ISSUE_STATUS_ADDR, {28'h000_0000, 1'b1, CPRL_CLASS_COPROC, 1'b0}, "issue_status");
        cprl_host_model_i.show(1'b0, 1'b0, 1'b0);
        cprl_host_model_i.hold(1'b0, 1'b0);
        @(negedge hclk);
        chk("advance", 1, coproc_advance);
        $display("test decode done");
        for (i = 0; i < 5; i++) begin
            op = cprl_op_type'(i);
            cprl_host_model_i.issue(op, 1'b0, 1'b1, 1'b0, 4'(i), 32'hC0DE_0000 + i);
            cprl_host_model_i.show(1'b0, 1'b0, 1'b0);
            wait_wb(op inside {CPRL_OP_SINGLE, CPRL_OP_MOVE} ? 1 : PIPE_LATENCY, 4'(i), 32'hC0DE_0000 + i);
        end
        cprl_host_model_i.issue(CPRL_OP_CMPY, 1'b0, 1'b1, 1'b0, 4'h3, 32'h1111_2222);
        cprl_host_model_i.issue(CPRL_OP_SINGLE, 1'b1, 1'b0, 1'b0, 4'h7, 32'h0);
        cprl_host_model_i.show(1'b0, 1'b0, 1'b0);
        wait_wb(1, 4'h3, 32'h1111_2222);
        cprl_host_model_i.issue(CPRL_OP_CMPY, 1'b0, 1'b1, 1'b0, 4'h2, 32'h2222_0000);
        cprl_host_model_i.issue(CPRL_OP_CMAC, 1'b0, 1'b1, 1'b0, 4'h6, 32'h6666_0000);
        cprl_host_model_i.show(1'b0, 1'b0, 1'b0);
        wait_wb(1, 4'h2, 32'h2222_0000);
        wait_wb(1, 4'h6, 32'h6666_0000);
        cprl_host_model_i.issue(CPRL_OP_BM_RATE3, 1'b0, 1'b1, 1'b1, 4'h9, 32'h9999_0000);
        cprl_host_model_i.show(1'b0, 1'b0, 1'b0);
        @(negedge hclk);
        chk("move_wb", 1, move_wb_valid);
        wait_wb(1, 4'h9, 32'h9999_0000);
        cprl_host_model_i.issue(CPRL_OP_CMPY, 1'b0, 1'b1, 1'b0, 4'hC, 32'hCCCC_0000);
        cprl_host_model_i.show(1'b0, 1'b0, 1'b0);
        cprl_host_model_i.hold(1'b0, 1'b1);
        repeat (3) @(posedge hclk);
        cprl_host_model_i.hold(1'b0, 1'b0);
        wait_wb(2, 4'hC, 32'hCCCC_0000);
        $display("test pipeline done");
        finish_test();
    end
endmodule
